// *** rtl/rx_free_fetch_map.svh ***
`ifndef RX_FREE_FETCH_MAP_SVH
`define RX_FREE_FETCH_MAP_SVH

`define OFS_BASE_LOW     12'h700
`define OFS_BASE_HIGH    12'h704
`define OFS_END_INDEX    12'h708
`define OFS_SMALL_START  12'h70c
`define OFS_LARGE_WP     12'h710
`define OFS_SMALL_WP     12'h714
`define OFS_LARGE_RP     12'h718
`define OFS_SMALL_RP     12'h71c
`define OFS_QUEUE_CTRL   12'h780
`define OFS_DMA_CONFIG   12'h790
`define OFS_DMA_STATUS   12'h794

`define QCTL_FREE_BURST  0
`define QCTL_LARGE_FLUSH 2
`define QCTL_SMALL_FLUSH 3
`define QCTL_WR_MASK     16'h073d
`define QCTL_RESET       16'h0000

`define CFG_RX_DMA_EN    0
`define CFG_IRQ_EN_LSB   4
`define CFG_WR_MASK      16'h00f1
`define CFG_RESET        16'h0000

`define STS_LARGE_READ   0
`define STS_SMALL_READ   1
`define STS_LARGE_ERR    2
`define STS_SMALL_ERR    3

`define DESC_BYTES       32'h0000_0008
`define WORD_BYTES       32'h0000_0004
`define CAP_SINGLE       5'h10
`define CAP_DUAL         5'h08
`define WM_SINGLE        5'h04
`define WM_DUAL          5'h02

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// *** rtl/rx_free_fetch_pkg.sv ***
package rx_free_fetch_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ0,
    ST_WAIT0,
    ST_REQ1,
    ST_WAIT1
  } fetch_state_e;
endpackage

// *** rtl/rx_free_queue_fetch.sv ***
`timescale 1ns/1ps
`include "rx_free_fetch_map.svh"
// Functional notes
// RQ1 - Large address is base plus pointer times eight.
// RQ2 - Small address adds start and pointer, each times eight.
// RQ3 - Start and end are indices; end is base+8*end.
// RQ4 - Fetch only after rx DMA enable set.
// RQ5 - Advance read pointer one descriptor per fetch.
// RQ6 - Wrap pointer to zero at start or end.
// RQ7 - Set large or small read flag per fetch.
// RQ8 - Empty queue sets error flag, no read.
// RQ9 - Each flag can raise interrupt when enabled.
// RQ10 - Prefetch FIFO holds sixteen descriptors.
// RQ11 - Single mode when start equals end.
// RQ12 - Dual splits FIFO eight/eight, single uses sixteen.
// RQ13 - Burst waits for low watermark, then refills.
// RQ14 - Burst fetches only what host has written.
// RQ15 - Burst reads, advances pointer, sets read flag.
// RQ16 - Control bit zero selects burst or single.
// RQ17 - Large flush bit discards large FIFO entries.
// RQ18 - Small flush bit discards small FIFO entries.
// RQ19 - Host matches FIFO setup to queue mode.
// RQ20 - Control holds done-queue bits, reset zero.
// RQ21 - Queue empty when read equals write pointer.
// RQ22 - Host never fills the last queue slot.
// RQ23 - Device changes read, host write pointers.
// RQ24 - Entry is address word then index word.
// RQ25 - Host advances write pointers, same wrap.
module rx_free_queue_fetch
  import rx_free_fetch_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             MEM_REQ,
  output logic [31:0]      MEM_ADDR,
  input  wire logic        MEM_GNT,
  input  wire logic        MEM_RVALID,
  input  wire logic [31:0] MEM_RDATA,
  output logic             LARGE_VALID,
  input  wire logic        LARGE_READY,
  output logic [31:0]      LARGE_BUF_ADDR,
  output logic [15:0]      LARGE_DESC_INDEX,
  output logic             SMALL_VALID,
  input  wire logic        SMALL_READY,
  output logic [31:0]      SMALL_BUF_ADDR,
  output logic [15:0]      SMALL_DESC_INDEX,
  output logic [3:0]       DMA_STATUS,
  output logic             IRQ
);

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    wr16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction
  function automatic logic [31:0] addr_of(input logic [31:0] base, input logic [15:0] off,
                                          input logic [15:0] ptr);
    addr_of = base + {16'h0, off} * `DESC_BYTES + {16'h0, ptr} * `DESC_BYTES;
  endfunction
  function automatic logic [15:0] avail(input logic [15:0] wp, input logic [15:0] rp,
                                        input logic [15:0] size);
    avail = (wp >= rp) ? wp - rp : wp + size - rp;
  endfunction
  function automatic logic [15:0] step(input logic [15:0] rp, input logic [15:0] size);
    step = (rp + 16'h1 >= size) ? 16'h0 : rp + 16'h1;
  endfunction
  function automatic logic [3:0] slot(input logic q, input logic dual, input logic [3:0] p);
    slot = q ? {1'b1, p[2:0]} : (dual ? {1'b0, p[2:0]} : p);
  endfunction

  logic [15:0]  base_lo_ff, base_hi_ff, end_ff, sbs_ff;
  logic [15:0]  lwp_ff, swp_ff, lrp_ff, srp_ff;
  logic [15:0]  qctl_ff, cfg_ff;
  logic [3:0]   sts_ff;
  logic [11:0]  awaddr_ff;
  logic         aw_got_ff, w_got_ff;
  logic [31:0]  wdata_ff;
  logic [3:0]   wstrb_ff;
  logic         bvalid_ff, rvalid_ff;
  logic [1:0]   bresp_ff, rresp_ff;
  logic [31:0]  rdata_ff;
  logic [47:0]  mem_ff [16];
  logic [3:0]   lw_ff, lr_ff, sw_ff, sr_ff;
  logic [4:0]   lcnt_ff, scnt_ff;
  fetch_state_e state_ff;
  logic         q_ff;
  logic [4:0]   rem_ff;
  logic [31:0]  word0_ff, maddr_ff;

  logic        do_wr, wr_hit, rd_hit, dual, burst, run, lflush, sflush;
  logic [31:0] base;
  logic [15:0] size_l, size_s, avail_l, avail_s, cur_rp, cur_size, cur_off, adv_rp;
  logic [4:0]  cap, wm, room_l, room_s, room;
  logic        need_l, need_s, go_l, go_s, push, last, lpop, spop;
  logic [31:0] rd_mux;
  logic [3:0]  sts_set, sts_clr;

  assign base   = {base_hi_ff, base_lo_ff};
  assign dual   = (sbs_ff != end_ff);                               // see RQ11
  assign burst  = qctl_ff[`QCTL_FREE_BURST];                        // see RQ16
  assign lflush = qctl_ff[`QCTL_LARGE_FLUSH];
  assign sflush = qctl_ff[`QCTL_SMALL_FLUSH];
  assign run    = cfg_ff[`CFG_RX_DMA_EN];                           // see RQ4
  assign size_l = sbs_ff;
  assign size_s = end_ff - sbs_ff;                                  // see RQ3
  assign avail_l = avail(lwp_ff, lrp_ff, size_l);                   // see RQ21
  assign avail_s = avail(swp_ff, srp_ff, size_s);
  assign cap    = dual ? `CAP_DUAL : `CAP_SINGLE;                   // see RQ10
  assign wm     = dual ? `WM_DUAL : `WM_SINGLE;                     // see RQ12
  assign room_l = cap - lcnt_ff;
  assign room_s = `CAP_DUAL - scnt_ff;

  // Single mode refills only when empty; burst mode waits for the watermark.
  assign need_l = run && !lflush && (burst ? lcnt_ff <= wm : lcnt_ff == 5'h0);  // see RQ13
  assign need_s = run && dual && !sflush && (burst ? scnt_ff <= wm : scnt_ff == 5'h0);
  assign go_l   = need_l && avail_l != 16'h0;                       // see RQ8
  assign go_s   = need_s && avail_s != 16'h0;

  assign room = q_ff ? room_s : room_l;
  assign cur_rp   = q_ff ? srp_ff : lrp_ff;
  assign cur_size = q_ff ? size_s : size_l;
  assign cur_off  = q_ff ? sbs_ff : 16'h0;
  assign adv_rp   = step(cur_rp, cur_size);                         // see RQ6
  assign push = (state_ff == ST_WAIT1) && MEM_RVALID;
  assign last = (rem_ff == 5'h1);
  assign lpop = LARGE_VALID && LARGE_READY;
  assign spop = SMALL_VALID && SMALL_READY;
  assign AWREADY = !aw_got_ff;
  assign WREADY  = !w_got_ff;
  assign ARREADY = !rvalid_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign RVALID  = rvalid_ff;
  assign RRESP   = rresp_ff;
  assign RDATA   = rdata_ff;
  assign do_wr   = aw_got_ff && w_got_ff && !bvalid_ff;

  always_comb begin
    wr_hit = 1'b1;
    case (awaddr_ff)
      `OFS_BASE_LOW, `OFS_BASE_HIGH, `OFS_END_INDEX, `OFS_SMALL_START, `OFS_LARGE_WP,
      `OFS_SMALL_WP, `OFS_LARGE_RP, `OFS_SMALL_RP, `OFS_QUEUE_CTRL, `OFS_DMA_CONFIG,
      `OFS_DMA_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0;
    case (ARADDR)
      `OFS_BASE_LOW:    rd_mux = {16'h0, base_lo_ff};
      `OFS_BASE_HIGH:   rd_mux = {16'h0, base_hi_ff};
      `OFS_END_INDEX:   rd_mux = {16'h0, end_ff};
      `OFS_SMALL_START: rd_mux = {16'h0, sbs_ff};
      `OFS_LARGE_WP:    rd_mux = {16'h0, lwp_ff};
      `OFS_SMALL_WP:    rd_mux = {16'h0, swp_ff};
      `OFS_LARGE_RP:    rd_mux = {16'h0, lrp_ff};
      `OFS_SMALL_RP:    rd_mux = {16'h0, srp_ff};
      `OFS_QUEUE_CTRL:  rd_mux = {16'h0, qctl_ff};
      `OFS_DMA_CONFIG:  rd_mux = {16'h0, cfg_ff};
      `OFS_DMA_STATUS:  rd_mux = {28'h0, sts_ff};
      default:          rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 12'h0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else begin
      if (AWVALID && !aw_got_ff) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= {AWADDR[11:2], 2'b00};
      end else if (do_wr) begin
        aw_got_ff <= 1'b0;
      end
      if (WVALID && !w_got_ff) begin
        w_got_ff <= 1'b1;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end else if (do_wr) begin
        w_got_ff <= 1'b0;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= `RESP_OKAY;
    end else if (ARVALID && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Only software writes the queue geometry and the host write pointers.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      base_lo_ff <= 16'h0;
      base_hi_ff <= 16'h0;
      end_ff     <= 16'h0;
      sbs_ff     <= 16'h0;
      lwp_ff     <= 16'h0;
      swp_ff     <= 16'h0;
      qctl_ff    <= `QCTL_RESET;                                    // see RQ20
      cfg_ff     <= `CFG_RESET;
    end else if (do_wr) begin
      case (awaddr_ff)
        `OFS_BASE_LOW:    base_lo_ff <= wr16(base_lo_ff, wdata_ff, wstrb_ff);
        `OFS_BASE_HIGH:   base_hi_ff <= wr16(base_hi_ff, wdata_ff, wstrb_ff);
        `OFS_END_INDEX:   end_ff <= wr16(end_ff, wdata_ff, wstrb_ff);
        `OFS_SMALL_START: sbs_ff <= wr16(sbs_ff, wdata_ff, wstrb_ff);
        `OFS_LARGE_WP:    lwp_ff <= wr16(lwp_ff, wdata_ff, wstrb_ff);  // see RQ23
        `OFS_SMALL_WP:    swp_ff <= wr16(swp_ff, wdata_ff, wstrb_ff);
        `OFS_QUEUE_CTRL:  qctl_ff <= wr16(qctl_ff, wdata_ff, wstrb_ff) & `QCTL_WR_MASK;
        `OFS_DMA_CONFIG:  cfg_ff <= wr16(cfg_ff, wdata_ff, wstrb_ff) & `CFG_WR_MASK;
        default: ;
      endcase
    end
  end

  // Read pointers are set by software at setup and then advanced by the fetcher.
  // A software write in the same cycle as an advance wins, since it only happens at setup.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      lrp_ff <= 16'h0;
      srp_ff <= 16'h0;
    end else begin
      if (do_wr && awaddr_ff == `OFS_LARGE_RP && wstrb_ff[1:0] != 2'b00) begin
        lrp_ff <= wr16(lrp_ff, wdata_ff, wstrb_ff);
      end else if (push && !q_ff) begin
        lrp_ff <= adv_rp;                                           // see RQ5
      end
      if (do_wr && awaddr_ff == `OFS_SMALL_RP && wstrb_ff[1:0] != 2'b00) begin
        srp_ff <= wr16(srp_ff, wdata_ff, wstrb_ff);
      end else if (push && q_ff) begin
        srp_ff <= adv_rp;                                           // see RQ5
      end
    end
  end

  always_comb begin
    sts_set = 4'h0;
    if (state_ff == ST_IDLE) begin
      sts_set[`STS_LARGE_ERR] = need_l && avail_l == 16'h0;         // see RQ8
      sts_set[`STS_SMALL_ERR] = need_s && avail_s == 16'h0;
      sts_set[`STS_LARGE_READ] = go_l;                              // see RQ7
      sts_set[`STS_SMALL_READ] = !go_l && go_s;                     // see RQ15
    end
    sts_clr = (do_wr && awaddr_ff == `OFS_DMA_STATUS && wstrb_ff[0]) ? wdata_ff[3:0] : 4'h0;
  end

  // Status bits clear by writing one; a new event in the same cycle keeps the bit set.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sts_ff <= 4'h0;
    end else begin
      sts_ff <= (sts_ff & ~sts_clr) | sts_set;
    end
  end

  assign DMA_STATUS = sts_ff;
  assign IRQ = |(sts_ff & cfg_ff[`CFG_IRQ_EN_LSB +: 4]);            // see RQ9
  // Fetch sequencer: two word reads per descriptor, one outstanding at a time.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_ff <= ST_IDLE;
      q_ff     <= 1'b0;
      rem_ff   <= 5'h0;
      word0_ff <= 32'h0;
      maddr_ff <= 32'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (go_l) begin
            state_ff <= ST_REQ0;
            q_ff     <= 1'b0;
            rem_ff   <= (!burst) ? 5'h1 :
                        (avail_l < {11'h0, room_l}) ? avail_l[4:0] : room_l;  // see RQ14
            maddr_ff <= addr_of(base, 16'h0, lrp_ff);              // see RQ1
          end else if (go_s) begin
            state_ff <= ST_REQ0;
            q_ff     <= 1'b1;
            rem_ff   <= (!burst) ? 5'h1 :
                        (avail_s < {11'h0, room_s}) ? avail_s[4:0] : room_s;  // see RQ14
            maddr_ff <= addr_of(base, sbs_ff, srp_ff);             // see RQ2
          end
        end
        ST_REQ0: begin
          if (MEM_GNT) begin
            state_ff <= ST_WAIT0;
          end
        end
        ST_WAIT0: begin
          if (MEM_RVALID) begin
            word0_ff <= MEM_RDATA;                                  // see RQ24
            maddr_ff <= maddr_ff + `WORD_BYTES;
            state_ff <= ST_REQ1;
          end
        end
        ST_REQ1: begin
          if (MEM_GNT) begin
            state_ff <= ST_WAIT1;
          end
        end
        ST_WAIT1: begin
          if (MEM_RVALID) begin
            rem_ff   <= rem_ff - 5'h1;
            maddr_ff <= addr_of(base, cur_off, adv_rp);
            state_ff <= last ? ST_IDLE : ST_REQ0;                   // see RQ15
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  assign MEM_REQ  = (state_ff == ST_REQ0) || (state_ff == ST_REQ1);
  assign MEM_ADDR = maddr_ff;
  // Descriptors fetched while a flush is held are dropped; the read pointer still moves.
  always_ff @(posedge CLK) begin
    if (push && !(q_ff ? sflush : lflush)) begin
      mem_ff[slot(q_ff, dual, q_ff ? sw_ff : lw_ff)] <= {word0_ff, MEM_RDATA[15:0]};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B || lflush) begin
      lw_ff   <= 4'h0;                                              // see RQ17
      lr_ff   <= 4'h0;
      lcnt_ff <= 5'h0;
    end else begin
      if (push && !q_ff) begin
        lw_ff <= lw_ff + 4'h1;
      end
      if (lpop) begin
        lr_ff <= lr_ff + 4'h1;
      end
      lcnt_ff <= lcnt_ff + {4'h0, push && !q_ff} - {4'h0, lpop};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B || sflush) begin
      sw_ff   <= 4'h0;                                              // see RQ18
      sr_ff   <= 4'h0;
      scnt_ff <= 5'h0;
    end else begin
      if (push && q_ff) begin
        sw_ff <= sw_ff + 4'h1;
      end
      if (spop) begin
        sr_ff <= sr_ff + 4'h1;
      end
      scnt_ff <= scnt_ff + {4'h0, push && q_ff} - {4'h0, spop};
    end
  end

  assign LARGE_VALID      = (lcnt_ff != 5'h0);
  assign LARGE_BUF_ADDR   = mem_ff[slot(1'b0, dual, lr_ff)][47:16];
  assign LARGE_DESC_INDEX = mem_ff[slot(1'b0, dual, lr_ff)][15:0];
  assign SMALL_VALID      = (scnt_ff != 5'h0);
  assign SMALL_BUF_ADDR   = mem_ff[slot(1'b1, dual, sr_ff)][47:16];
  assign SMALL_DESC_INDEX = mem_ff[slot(1'b1, dual, sr_ff)][15:0];

endmodule

// *** test/rx_free_fetch_assertions.sv ***
`timescale 1ns/1ps
module rx_free_fetch_assertions (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic        MEM_REQ,
  input wire logic [31:0] MEM_ADDR,
  input wire logic        MEM_GNT,
  input wire logic        MEM_RVALID,
  input wire logic        LARGE_VALID,
  input wire logic        LARGE_READY,
  input wire logic [31:0] LARGE_BUF_ADDR,
  input wire logic [3:0]  DMA_STATUS,
  input wire logic        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic pend_ff;
  // A granted word stays outstanding until its data returns.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pend_ff <= 1'b0;
    end else if (MEM_REQ && MEM_GNT) begin
      pend_ff <= 1'b1;
    end else if (MEM_RVALID) begin
      pend_ff <= 1'b0;
    end
  end
  property p_b_after_aw; AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID; endproperty
  a_b_after_aw: assert property (p_b_after_aw) else $error("write response late");
  property p_b_hold; BVALID && !BREADY |=> BVALID; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_after_ar; ARVALID && ARREADY |=> RVALID && !ARREADY; endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("read data late");
  property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_req_hold; MEM_REQ && !MEM_GNT |=> MEM_REQ && $stable(MEM_ADDR); endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request not held");
  property p_one_word; pend_ff |-> !MEM_REQ; endproperty
  a_one_word: assert property (p_one_word) else $error("second word requested early");
  property p_word_pair;
    MEM_RVALID && pend_ff && !MEM_ADDR[2] |=> MEM_REQ && MEM_ADDR == $past(MEM_ADDR) + 32'h4;
  endproperty
  a_word_pair: assert property (p_word_pair) else $error("index word not fetched");
  property p_read_flag; $rose(MEM_REQ) && !MEM_ADDR[2] |-> DMA_STATUS[1:0] != 2'b00; endproperty
  a_read_flag: assert property (p_read_flag) else $error("read flag missing");
  property p_irq; IRQ |-> DMA_STATUS != 4'h0; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without status");
  property p_head; LARGE_VALID && !LARGE_READY |=> !LARGE_VALID || $stable(LARGE_BUF_ADDR); endproperty
  a_head: assert property (p_head) else $error("fifo head changed");
endmodule
bind rx_free_queue_fetch rx_free_fetch_assertions i_chk (
  .CLK, .RST_B, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .ARVALID, .ARREADY,
  .RVALID, .RREADY, .RDATA, .MEM_REQ, .MEM_ADDR, .MEM_GNT, .MEM_RVALID, .LARGE_VALID,
  .LARGE_READY, .LARGE_BUF_ADDR, .DMA_STATUS, .IRQ);

// *** test/host_mem_model.sv ***
`timescale 1ns/1ps
module host_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_gnt,
  output logic             mem_rvalid,
  output logic [31:0]      mem_rdata
);
  logic [31:0] addr_ff;
  logic [2:0]  wait_ff;
  logic        busy_ff;
  // Word content is the address under a fixed pattern, so a misaddressed read shows.
  // Between returns the data lines toggle so stale data never passes for valid.
  always_ff @(posedge clk) begin
    mem_gnt    <= 1'b0;
    mem_rvalid <= 1'b0;
    mem_rdata  <= ~mem_rdata;
    if (!rst_b) begin
      busy_ff   <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (busy_ff) begin
      wait_ff <= wait_ff - 3'h1;
      if (wait_ff == 3'h0) begin
        busy_ff    <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata  <= addr_ff ^ 32'h5a5a_0000;
      end
    end else if (mem_req && mem_gnt) begin
      busy_ff <= 1'b1;
      addr_ff <= mem_addr;
      wait_ff <= slow ? 3'($urandom % 6) : 3'h0;
    end else if (mem_req) begin
      mem_gnt <= !slow || ($urandom % 2 == 0);
    end
  end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
`include "rx_free_fetch_map.svh"
`define CHK(n,e,s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, lrdy, srdy, hold, slow;
  logic        awready, wready, bvalid, arready, rvalid, mem_req, mem_gnt, mem_rvalid;
  logic        lvalid, svalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mem_addr, mem_rdata, lbuf, sbuf, base, rd, xl, xs;
  logic [15:0] lidx, sidx;
  logic [3:0]  sts, wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] lq[$], sq[$];
  int          n_mismatch, n_checks, cyc;
  rx_free_queue_fetch i_rx_free_queue_fetch (
    .CLK(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .MEM_REQ(mem_req),
    .MEM_ADDR(mem_addr), .MEM_GNT(mem_gnt), .MEM_RVALID(mem_rvalid), .MEM_RDATA(mem_rdata),
    .LARGE_VALID(lvalid), .LARGE_READY(lrdy), .LARGE_BUF_ADDR(lbuf), .LARGE_DESC_INDEX(lidx),
    .SMALL_VALID(svalid), .SMALL_READY(srdy), .SMALL_BUF_ADDR(sbuf), .SMALL_DESC_INDEX(sidx),
    .DMA_STATUS(sts), .IRQ(irq));
  host_mem_model i_host_mem_model (.clk(clk), .rst_b(rst_b), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  always #25 clk = ~clk;
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    lrdy <= !hold && ($urandom % 3 != 0);
    srdy <= !hold && ($urandom % 3 != 0);
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  always @(posedge clk) begin
    if (lvalid && lrdy) begin
      xl = lq.pop_front();
      `CHK("large_buf", xl ^ 32'h5a5a_0000, lbuf)
      `CHK("large_idx", xl[15:0] + 16'h4, lidx)
    end
    if (svalid && srdy) begin
      xs = sq.pop_front();
      `CHK("small_buf", xs ^ 32'h5a5a_0000, sbuf)
      `CHK("small_idx", xs[15:0] + 16'h4, sidx)
    end
  end
  task axw(input logic [11:0] a, input logic [15:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready) begin ad = 1; awvalid <= 1'b0; end
      if (!wd && wready) begin wd = 1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task axr(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Expected descriptor addresses, wrapping the way the read pointer must.
  task desc(input logic sm, input int off, input int rp, input int wp, input int size);
    while (rp != wp) begin
      if (sm) sq.push_back(base + 32'(8 * off + 8 * rp));
      else lq.push_back(base + 32'(8 * rp));
      rp = (rp + 1 >= size) ? 0 : rp + 1;
    end
  endtask
  task setq(input logic [15:0] e, st, lr, lw, sr, sw);
    axw(`OFS_END_INDEX, e);
    axw(`OFS_SMALL_START, st);
    axw(`OFS_LARGE_RP, lr);
    axw(`OFS_LARGE_WP, lw);
    axw(`OFS_SMALL_RP, sr);
    axw(`OFS_SMALL_WP, sw);
  endtask
  task drain;
    while (lq.size() + sq.size() != 0) @(posedge clk);
    repeat (30) @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'h6584));
    {clk, rst_b, awvalid, wvalid, bready, arvalid, rready, lrdy, srdy, hold, slow} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    axr(`OFS_QUEUE_CTRL);
    `CHK("ctrl_reset", 32'h0, rd)
    axr(12'h7f0);
    `CHK("unmapped", `RESP_SLVERR, rs)
    axw(12'h7f0, 16'h0);
    `CHK("wr_unmapped", `RESP_SLVERR, rs)
    axw(`OFS_QUEUE_CTRL, 16'h07f0);
    `CHK("wr_okay", `RESP_OKAY, rs)
    axr(`OFS_QUEUE_CTRL);
    `CHK("ctrl_lane0", 32'h30, rd)
    wstrb <= 4'h3;
    axw(`OFS_QUEUE_CTRL, 16'h07f0);
    axr(`OFS_QUEUE_CTRL);
    `CHK("ctrl_done", 32'h0730, rd)
    axw(`OFS_QUEUE_CTRL, 16'h0);
    base = $urandom & 32'h0fff_fff8;
    axw(`OFS_BASE_LOW, base[15:0]);
    axw(`OFS_BASE_HIGH, base[31:16]);
    setq(16'h8, 16'h8, 16'h6, 16'h2, 16'h0, 16'h0);
    repeat (10) @(posedge clk);
    `CHK("idle_status", 4'h0, sts)
    desc(0, 0, 6, 2, 8);
    axw(`OFS_DMA_CONFIG, 16'h0011);
    drain;
    axr(`OFS_LARGE_RP);
    `CHK("large_rp", 32'h2, rd)
    `CHK("status_a", 4'h5, sts)
    `CHK("irq_on", 1'b1, irq)
    axw(`OFS_DMA_CONFIG, 16'h0001);
    `CHK("irq_masked", 1'b0, irq)
    axw(`OFS_DMA_CONFIG, 16'h0);
    axw(`OFS_DMA_STATUS, 16'h000f);
    axr(`OFS_DMA_STATUS);
    `CHK("status_clr", 32'h0, rd)
    axw(`OFS_QUEUE_CTRL, 16'h000d);
    axw(`OFS_QUEUE_CTRL, 16'h0001);
    slow <= 1'b1;
    setq(16'hc, 16'h4, 16'h3, 16'h1, 16'h6, 16'h5);
    desc(0, 0, 3, 1, 4);
    desc(1, 4, 6, 5, 8);
    axw(`OFS_DMA_CONFIG, 16'h0021);
    drain;
    axr(`OFS_LARGE_RP);
    `CHK("large_rp_b", 32'h1, rd)
    axr(`OFS_SMALL_RP);
    `CHK("small_rp_b", 32'h5, rd)
    `CHK("read_flags", 2'b11, sts[1:0])
    `CHK("irq_small", 1'b1, irq)
    hold <= 1'b1;
    axw(`OFS_LARGE_WP, 16'h3);
    axw(`OFS_SMALL_WP, 16'h0);
    repeat (200) @(posedge clk);
    `CHK("large_held", 1'b1, lvalid)
    `CHK("small_held", 1'b1, svalid)
    axw(`OFS_QUEUE_CTRL, 16'h000d);
    axw(`OFS_QUEUE_CTRL, 16'h0001);
    `CHK("large_flush", 1'b0, lvalid)
    `CHK("small_flush", 1'b0, svalid)
    axw(`OFS_DMA_CONFIG, 16'h0);
    slow <= 1'b0;
    setq(16'h20, 16'h20, 16'h0, 16'h14, 16'h0, 16'h0);
    desc(0, 0, 0, 20, 32);
    axw(`OFS_DMA_CONFIG, 16'h0001);
    repeat (300) @(posedge clk);
    axr(`OFS_LARGE_RP);
    `CHK("large_rp_cap", 32'h10, rd)
    hold <= 1'b0;
    drain;
    axr(`OFS_LARGE_RP);
    `CHK("large_rp_c", 32'h14, rd)
    report_and_stop;
  end
endmodule
